// ### bench/gst_osc_model.sv
// far side: secondary oscillator pin and gate pin source
// assumes the run request from the timer; the clock stands low while not requested
module gst_osc_model (
    input wire logic run,
    input wire logic gate_level,
    output logic secondary_oscillator,
    output logic gate_input
);
    timeunit 1ns;
    timeprecision 100ps;
    // 40 ns period puts the pin at a quarter of the system clock for the synchroniser
    initial begin
        secondary_oscillator = 1'b0;
        #7;
        forever begin
            #20;
            secondary_oscillator = run ? ~secondary_oscillator : 1'b0;
        end
    end
    assign gate_input = gate_level;
endmodule

// ### bench/gst_timer_monitor.sv
// concurrent checks on the gated timer register port, run request and interrupt
// assumes a bind onto gst_timer; sees only its ports
`include "gst_defines.svh"
module gst_timer_monitor
    import gst_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic [`GST_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic secondary_oscillator,
    input wire logic gate_input,
    input wire logic secondary_osc_run,
    input wire logic irq
);
    logic buf_reg;
    logic en_reg;
    // shadows of buffered mode and irq enable, rebuilt from the writes alone
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            buf_reg <= 1'b0;
            en_reg <= 1'b0;
        end else if (reg_wr && reg_addr == `GST_OFS_CTRL) begin
            buf_reg <= reg_wdata[`GST_CTRL_SIXTEEN_BIT_ACCESS_SELECT];
        end else if (reg_wr && reg_addr == `GST_OFS_IRQ_EN) begin
            en_reg <= reg_wdata[`GST_IRQ_OVF];
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////////////////////////////////////
    // read data only in the slot after a read strobe
    rd_slot_only_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside its slot");
    unmapped_read_zero_a: assert property (reg_rd && (reg_addr > `GST_OFS_SECONDARY_OSCILLATOR_EN_OTHERS
        || reg_addr == `GST_OFS_IRQ_CLR) |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
    osc_by_ctrl_a: assert property (reg_wr && reg_addr == `GST_OFS_CTRL
        && reg_wdata[`GST_CTRL_SECONDARY_OSC_ENABLE] |=> secondary_osc_run) else $error("osc enable ignored");
    osc_by_force_a: assert property (reg_wr && reg_addr == `GST_OFS_OSC2
        && reg_wdata[`GST_OSC2_FORCE] |=> secondary_osc_run) else $error("osc force ignored");
    osc_by_others_a: assert property (reg_wr && reg_addr == `GST_OFS_SECONDARY_OSCILLATOR_EN_OTHERS
        && (|reg_wdata[2:0]) |=> secondary_osc_run) else $error("other osc enable ignored");
    irq_masked_a: assert property (!en_reg |-> !irq) else $error("irq while disabled");
    stat_shows_irq_a: assert property (reg_rd && reg_addr == `GST_OFS_IRQ_STAT && irq
        |=> reg_rdata[`GST_IRQ_OVF]) else $error("status misses overflow");
    buffer_holds_a: assert property (buf_reg && reg_wr && reg_addr == `GST_OFS_CNT_HI
        ##1 !reg_rd ##1 reg_rd && reg_addr == `GST_OFS_CNT_HI |=> reg_rdata == $past(reg_wdata, 3))
        else $error("high buffer lost its value");
endmodule

// ### bench/tb_top.sv
// self-checking bench for gst_timer with a read scoreboard
// assumes the oscillator model and the bound monitor beside it
`include "gst_defines.svh"
`define CHK(nm, e, a) begin checks++; if ((a) !== (e)) begin n_errors++; \
    $display("wrong value %s exp %h got %h", nm, e, a); end end
module tb_top
    import gst_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys = 1'b0, rst_b = 1'b0, clk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, rd_q = 1'b0;
    logic [`GST_ADDR_W-1:0] reg_addr = 4'h0;
    gst_byte_t reg_wdata = 8'h00, reg_rdata, e;
    logic secondary_oscillator, gate_input, secondary_osc_run, irq, gate_level = 1'b0, ge, pol, g;
    gst_byte_t exp_q[$];
    int n_errors = 0, checks = 0, seed = 89953;
    always #5 clk_sys = ~clk_sys;
    gst_timer dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .secondary_oscillator(secondary_oscillator), .gate_input(gate_input),
        .secondary_osc_run(secondary_osc_run), .irq(irq));
    gst_osc_model osc_u (.run(secondary_osc_run), .gate_level(gate_level),
        .secondary_oscillator(secondary_oscillator), .gate_input(gate_input));
    ////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [3:0] a, input gst_byte_t d);
        @(posedge clk_sys);
        reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    // expectation is queued by the driver, checked by the watcher below
    task automatic rd(input logic [3:0] a, input gst_byte_t d);
        @(posedge clk_sys);
        reg_rd <= 1'b1; reg_addr <= a; exp_q.push_back(d);
        @(posedge clk_sys);
        reg_rd <= 1'b0;
    endtask
    task automatic stop_test;
        if (n_errors == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // read data is settled by the falling edge of the slot after the strobe
    always @(posedge clk_sys) rd_q <= reg_rd;
    always @(negedge clk_sys) if (rd_q && exp_q.size() > 0) begin
        e = exp_q.pop_front();
        `CHK("reg_rdata", e, reg_rdata)
    end
    initial begin
        #400000;
        n_errors++;
        stop_test();
    end
    initial begin
        repeat (6) @(posedge clk_sys);
        rst_b <= 1'b1;
        wr(`GST_OFS_IRQ_STAT, 8'hff); // status is read-only
        for (int a = 0; a < 10; a++) rd((a == 9) ? 4'hf : 4'(a), 8'h00);
        // overflow from 0xfffd, then mask, unmask and clear
        wr(`GST_OFS_CNT_HI, 8'hff);
        wr(`GST_OFS_CNT_LO, 8'hfd);
        rd(`GST_OFS_CNT_HI, 8'hff);
        wr(`GST_OFS_IRQ_EN, 8'h01);
        wr(`GST_OFS_CTRL, 8'h01);
        repeat (4) @(posedge clk_sys);
        `CHK("irq", 1'b1, irq)
        rd(`GST_OFS_IRQ_STAT, 8'h01);
        wr(`GST_OFS_IRQ_EN, 8'h00);
        @(negedge clk_sys); // let the write edge settle before looking at irq
        `CHK("irq", 1'b0, irq)
        wr(`GST_OFS_IRQ_EN, 8'h01);
        wr(`GST_OFS_IRQ_CLR, 8'h01);
        @(negedge clk_sys);
        `CHK("irq", 1'b0, irq)
        // buffered access with the counter stopped
        wr(`GST_OFS_CTRL, 8'h02);
        wr(`GST_OFS_CNT_HI, 8'h5a);
        // counter stopped 11 steps past the wrap, at 0x000b
        rd(`GST_OFS_CNT_LO, 8'h0b);
        wr(`GST_OFS_CNT_HI, 8'h5a);
        wr(`GST_OFS_CNT_LO, 8'h34);
        wr(`GST_OFS_CNT_HI, 8'h77);
        rd(`GST_OFS_CNT_HI, 8'h77);
        wr(`GST_OFS_CTRL, 8'h00);
        rd(`GST_OFS_CNT_HI, 8'h5a);
        rd(`GST_OFS_CNT_LO, 8'h34);
        wr(`GST_OFS_CNT_HI, 8'h12);
        wr(`GST_OFS_CTRL, 8'h02);
        rd(`GST_OFS_CNT_LO, 8'h34);
        rd(`GST_OFS_CNT_HI, 8'h12);
        wr(`GST_OFS_CTRL, 8'h00);
        // gate enable, polarity and level at random; ten system clocks open
        for (int i = 0; i < 8; i++) begin
            ge = 1'($random(seed));
            pol = 1'($random(seed));
            g = 1'($random(seed));
            gate_level <= g;
            wr(`GST_OFS_GATE, {ge, pol, 6'h00});
            wr(`GST_OFS_CNT_LO, 8'h00);
            wr(`GST_OFS_CNT_HI, 8'h00);
            wr(`GST_OFS_CTRL, 8'h01);
            repeat (8) @(posedge clk_sys);
            wr(`GST_OFS_CTRL, 8'h00);
            rd(`GST_OFS_CNT_LO, (!ge || g == pol) ? 8'h0a : 8'h00);
        end
        // oscillator as counter clock; count window allows for sync latency
        wr(`GST_OFS_GATE, 8'h00);
        wr(`GST_OFS_CNT_LO, 8'h00);
        wr(`GST_OFS_CTRL, 8'h0d);
        repeat (100) @(posedge clk_sys);
        wr(`GST_OFS_CTRL, 8'h08);
        @(posedge clk_sys);
        reg_rd <= 1'b1; reg_addr <= `GST_OFS_CNT_LO;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        `CHK("osc_count", 1'b1, reg_rdata >= 8'd20 && reg_rdata <= 8'd27)
        wr(`GST_OFS_CTRL, 8'h00);
        @(negedge clk_sys);
        `CHK("secondary_osc_run", 1'b0, secondary_osc_run)
        wr(`GST_OFS_OSC2, 8'h08);
        wr(`GST_OFS_OSC2, 8'h00);
        wr(`GST_OFS_SECONDARY_OSCILLATOR_EN_OTHERS, 8'h04);
        wr(`GST_OFS_SECONDARY_OSCILLATOR_EN_OTHERS, 8'h00);
        @(negedge clk_sys);
        `CHK("secondary_osc_run", 1'b0, secondary_osc_run)
        repeat (4) @(posedge clk_sys);
        stop_test();
    end
endmodule
bind gst_timer gst_timer_monitor mon_u (.clk_sys(clk_sys), .rst_b(rst_b), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .secondary_oscillator(secondary_oscillator), .gate_input(gate_input),
    .secondary_osc_run(secondary_osc_run), .irq(irq));

// ### src/gst_defines.svh
// register offsets, field positions and reset values for the gated 16-bit timer
// assumes inclusion by bare name from package and modules
`ifndef GST_DEFINES_SVH
`define GST_DEFINES_SVH
`define GST_ADDR_W 4
`define GST_OFS_CTRL 4'h0
`define GST_OFS_GATE 4'h1
`define GST_OFS_CNT_LO 4'h2
`define GST_OFS_CNT_HI 4'h3
`define GST_OFS_OSC2 4'h4
`define GST_OFS_IRQ_STAT 4'h5
`define GST_OFS_IRQ_CLR 4'h6
`define GST_OFS_IRQ_EN 4'h7
`define GST_OFS_SECONDARY_OSCILLATOR_EN_OTHERS 4'h8
`define GST_CTRL_ON 0
`define GST_CTRL_SIXTEEN_BIT_ACCESS_SELECT 1
`define GST_CTRL_CS 2
`define GST_CTRL_SECONDARY_OSC_ENABLE 3
`define GST_CTRL_PS_LO 4
`define GST_CTRL_PS_HI 5
`define GST_GATE_EN 7
`define GST_GATE_POL 6
`define GST_OSC2_FORCE 3
`define GST_IRQ_OVF 0
`define GST_CTRL_RST 8'h00
`define GST_GATE_RST 8'h00
`define GST_BYTE_ZERO 8'h00
`define GST_CNT_ONES 16'hffff
`define GST_CNT_ZERO 16'h0000
`define GST_PS_ZERO 3'h0
`define GST_OTHERS_RST 3'h0
`endif

// ### src/gst_edge_sync.sv
// two-flop synchroniser with rising-edge and level output
// assumes a raw asynchronous pin input and the system clock
module gst_edge_sync
    import gst_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic pin_in,
    output logic level,
    output logic rise
);
    logic meta_reg;
    logic sync_reg;
    logic last_reg;

    ////////////////////////////////////////////////////////////////////////
    // first flop feeds only the second; edge taken from stable copies
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            last_reg <= 1'b0;
        end else if (ce) begin
            meta_reg <= pin_in;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    assign level = sync_reg;
    assign rise = sync_reg & ~last_reg;
endmodule

// ### src/gst_pkg.sv
// types shared by the gated 16-bit timer
// assumes gst_defines.svh on the include path
`include "gst_defines.svh"
package gst_pkg;
    typedef logic [7:0] gst_byte_t;
    typedef logic [15:0] gst_count_t;
    typedef enum logic [1:0] {
        GST_SRC_SYS = 2'b01,
        GST_SRC_OSC = 2'b10
    } gst_src_t;
endpackage

// ### src/gst_timer.sv
// gated 16-bit timer: counter, buffered access, clock and gate selection
// assumes a byte register port on clk_sys; oscillator and gate arrive as raw pins
`include "gst_defines.svh"

////////////////////////////////////////////////////////////////////////////
module gst_timer
    import gst_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic [`GST_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic secondary_oscillator,
    input wire logic gate_input,
    output logic secondary_osc_run,
    output logic irq
);
    gst_byte_t timer_control_reg;
    gst_byte_t gate_control_reg;
    gst_byte_t osc_control_two_reg;
    logic [2:0] others_en_reg;
    gst_count_t count_reg;
    gst_count_t count_next;
    gst_byte_t hi_buf_reg;
    logic [2:0] ps_reg;
    logic [2:0] ps_next;
    logic irq_stat_reg;
    logic irq_en_reg;
    gst_byte_t rdata_reg;
    gst_byte_t rdata_next;
    gst_src_t src;
    logic osc_level;
    logic osc_rise;
    logic gate_level;
    logic gate_unused_rise;

    // prescale divide by 2^sel: tick when the low sel bits of the prescaler are all ones
    function automatic logic ps_tick(input logic [2:0] ps, input logic [1:0] sel);
        logic [2:0] mask;
        mask = 3'h0;
        case (sel)
            2'd0: mask = 3'h0;
            2'd1: mask = 3'h1;
            2'd2: mask = 3'h3;
            default: mask = 3'h7;
        endcase
        ps_tick = ((ps & mask) == mask);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers: oscillator and gate are asynchronous to clk_sys
    gst_edge_sync u_osc_sync (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .ce(clk_en),
        .pin_in(secondary_oscillator),
        .level(osc_level),
        .rise(osc_rise)
    );

    gst_edge_sync u_gate_sync (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .ce(clk_en),
        .pin_in(gate_input),
        .level(gate_level),
        .rise(gate_unused_rise)
    );

    ////////////////////////////////////////////////////////////////////////
    // oscillator run request and clock source choice
    // the oscillator is sampled, so it must run well below half of clk_sys
    assign secondary_osc_run = timer_control_reg[`GST_CTRL_SECONDARY_OSC_ENABLE] | (|others_en_reg)
                             | osc_control_two_reg[`GST_OSC2_FORCE];
    assign src = timer_control_reg[`GST_CTRL_CS] ? GST_SRC_OSC : GST_SRC_SYS;

    wire osc_usable = secondary_osc_run & osc_rise;
    wire clk_edge = (src == GST_SRC_OSC) ? osc_usable : 1'b1;

    // gate: count level chosen by polarity, ignored when gating is off
    wire gate_on = gate_control_reg[`GST_GATE_EN];
    wire gate_ok = (gate_level == gate_control_reg[`GST_GATE_POL]);
    wire count_allow = gate_on ? gate_ok : 1'b1;

    wire timer_on = timer_control_reg[`GST_CTRL_ON];
    wire step_edge = timer_on & clk_edge & count_allow;
    wire [1:0] ps_sel = timer_control_reg[`GST_CTRL_PS_HI:`GST_CTRL_PS_LO];
    wire inc = step_edge & ps_tick(ps_reg, ps_sel);
    wire wrap = inc & (count_reg == `GST_CNT_ONES);

    ////////////////////////////////////////////////////////////////////////
    // register decode
    wire buffered = timer_control_reg[`GST_CTRL_SIXTEEN_BIT_ACCESS_SELECT];
    wire wr_ctrl = reg_wr & (reg_addr == `GST_OFS_CTRL);
    wire wr_gate = reg_wr & (reg_addr == `GST_OFS_GATE);
    wire wr_lo = reg_wr & (reg_addr == `GST_OFS_CNT_LO);
    wire wr_hi = reg_wr & (reg_addr == `GST_OFS_CNT_HI);
    wire wr_osc2 = reg_wr & (reg_addr == `GST_OFS_OSC2);
    wire wr_clr = reg_wr & (reg_addr == `GST_OFS_IRQ_CLR);
    wire wr_ien = reg_wr & (reg_addr == `GST_OFS_IRQ_EN);
    wire wr_oth = reg_wr & (reg_addr == `GST_OFS_SECONDARY_OSCILLATOR_EN_OTHERS);
    wire rd_lo = reg_rd & (reg_addr == `GST_OFS_CNT_LO);

    // high byte seen at the high address: buffer in buffered mode, else live
    wire [7:0] hi_view = buffered ? hi_buf_reg : count_reg[15:8];

    always_comb begin
        if (reg_addr == `GST_OFS_CTRL) begin
            rdata_next = timer_control_reg;
        end else if (reg_addr == `GST_OFS_GATE) begin
            rdata_next = gate_control_reg;
        end else if (reg_addr == `GST_OFS_CNT_LO) begin
            rdata_next = count_reg[7:0];
        end else if (reg_addr == `GST_OFS_CNT_HI) begin
            rdata_next = hi_view;
        end else if (reg_addr == `GST_OFS_OSC2) begin
            rdata_next = osc_control_two_reg;
        end else if (reg_addr == `GST_OFS_IRQ_STAT) begin
            rdata_next = {7'h00, irq_stat_reg};
        end else if (reg_addr == `GST_OFS_IRQ_EN) begin
            rdata_next = {7'h00, irq_en_reg};
        end else if (reg_addr == `GST_OFS_SECONDARY_OSCILLATOR_EN_OTHERS) begin
            rdata_next = {5'h00, others_en_reg};
        end else begin
            rdata_next = `GST_BYTE_ZERO; // unmapped and write-only read as zero
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // next count: software writes take priority over the increment in that cycle
    always_comb begin
        count_next = count_reg;
        if (inc) begin
            count_next = count_reg + 16'h0001; // wraps to zero
        end
        if (wr_lo) begin
            if (buffered) begin
                count_next = {hi_buf_reg, reg_wdata}; // all 16 bits together
            end else begin
                count_next = {count_reg[15:8], reg_wdata};
            end
        end else if (wr_hi && !buffered) begin
            count_next = {reg_wdata, count_reg[7:0]}; // live write only when unbuffered
        end
    end

    // prescaler: cleared by a low-byte write only
    always_comb begin
        ps_next = ps_reg;
        if (wr_lo) begin
            ps_next = `GST_PS_ZERO;
        end else if (step_edge) begin
            ps_next = ps_reg + 3'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // control registers
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            timer_control_reg <= `GST_CTRL_RST;
            gate_control_reg <= `GST_GATE_RST;
            osc_control_two_reg <= `GST_BYTE_ZERO;
            others_en_reg <= `GST_OTHERS_RST;
            irq_en_reg <= 1'b0;
        end else if (clk_en) begin
            if (wr_ctrl) timer_control_reg <= reg_wdata;
            if (wr_gate) gate_control_reg <= reg_wdata;
            if (wr_osc2) osc_control_two_reg <= reg_wdata;
            if (wr_oth) others_en_reg <= reg_wdata[2:0];
            if (wr_ien) irq_en_reg <= reg_wdata[`GST_IRQ_OVF];
        end
    end

    // counter, prescaler and high-byte buffer
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            count_reg <= `GST_CNT_ZERO;
            ps_reg <= `GST_PS_ZERO;
            hi_buf_reg <= `GST_BYTE_ZERO;
        end else if (clk_en) begin
            count_reg <= count_next;
            ps_reg <= ps_next;
            if (buffered && wr_hi) begin
                hi_buf_reg <= reg_wdata; // buffer only
            end else if (buffered && rd_lo) begin
                hi_buf_reg <= count_reg[15:8]; // snapshot beside the low byte
            end
        end
    end

    // overflow flag: a new wrap beats a clear in the same cycle
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            irq_stat_reg <= 1'b0;
        end else if (clk_en) begin
            if (wrap) begin
                irq_stat_reg <= 1'b1;
            end else if (wr_clr && reg_wdata[`GST_IRQ_OVF]) begin
                irq_stat_reg <= 1'b0;
            end
        end
    end

    // read data stands one cycle after the strobe
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rdata_reg <= `GST_BYTE_ZERO;
        end else if (clk_en) begin
            rdata_reg <= reg_rd ? rdata_next : `GST_BYTE_ZERO;
        end
    end

    assign reg_rdata = rdata_reg;
    assign irq = irq_stat_reg & irq_en_reg;
endmodule
